// [rtl/emxc_pkg.sv]
// Constants, codes and state types of the external memory expansion controller.
// Assumes one 10 MHz clock and AXI4-Lite register access from the CPU side.
// Overview of operation
// - External bus cycles run only for addresses outside internal ROM, RAM and SFR space.
// - In expansion the low address/data byte, upper address and strobes use ports 4, 5, 6.
// - Each mode claims its own set of pins and leaves every other pin as a port.
// - A three-bit area code picks single-chip, edge detect, 256 B, 4 KB, 16 KB or full.
// - The area select register sits at index FF47, takes byte or bit writes, resets to 00.
// - In expansion, a read outside internal memory and the external window gives junk.
// - Full-address mode maps every non-internal address of the 64 KB space outside.
// - The wait config register sits at index FFF8, takes byte or bit writes, resets to 10.
// - A two-bit wait code picks no wait, one wait state or waits held by the wait pin.
// - Unless external waits are chosen, the wait pin stays an ordinary port bit.
// - The read strobe pulses for external reads and fetches and stays high otherwise.
// - The write strobe pulses only for external writes and stays high otherwise.
// - The address strobe comes on every bus cycle; the wait pin is ignored internally.
package emxc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] AREA_SEL_IDX  = 16'hff47;
    localparam logic [15:0] WAIT_CFG_IDX  = 16'hfff8;
    localparam int          AXI_AW        = 18;

    // Reset values and writable masks
    localparam logic [7:0]  AREA_SEL_RST  = 8'h00;
    localparam logic [7:0]  WAIT_CFG_RST  = 8'h10;
    localparam logic [7:0]  AREA_SEL_MASK = 8'h07;
    localparam logic [7:0]  WAIT_CFG_MASK = 8'h30;
    localparam int          WAIT_LSB      = 4;

    // Area codes
    localparam logic [2:0]  AREA_SINGLE   = 3'h0;
    localparam logic [2:0]  AREA_EDGE     = 3'h1;
    localparam logic [2:0]  AREA_256B     = 3'h3;
    localparam logic [2:0]  AREA_4K       = 3'h4;
    localparam logic [2:0]  AREA_16K      = 3'h5;
    localparam logic [2:0]  AREA_FULL     = 3'h7;

    // Window sizes and upper address pins claimed per mode
    localparam logic [16:0] WIN_256B      = 17'h00100;
    localparam logic [16:0] WIN_4K        = 17'h01000;
    localparam logic [16:0] WIN_16K       = 17'h04000;
    localparam logic [7:0]  HI_MASK_4K    = 8'h0f;
    localparam logic [7:0]  HI_MASK_16K   = 8'h3f;
    localparam logic [7:0]  HI_MASK_FULL  = 8'hff;

    // Wait codes
    localparam logic [1:0]  WAIT_NONE     = 2'h0;
    localparam logic [1:0]  WAIT_ONE      = 2'h1;
    localparam logic [1:0]  WAIT_EXT      = 2'h3;

    // Port 6 upper nibble positions
    localparam int          P6_RD         = 0;
    localparam int          P6_WR         = 1;
    localparam int          P6_WAIT       = 2;
    localparam int          P6_ADDR_LATCH_STROBE       = 3;

    // Bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [7:0]  UNDEF_DATA    = 8'hff;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_WAIT1,
        ST_DONE
    } emxc_state_t;

endpackage

// [rtl/emxc_ctrl.sv]
// External memory expansion controller: area/wait registers, CPU bus cycle
// sequencer and pin multiplexer for ports 4, 5 and the upper half of port 6.
// Assumes the port block supplies its own latch values and directions, the
// CPU holds cpu_req until cpu_ack, and all pin inputs are synchronous to mclk.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps

module emxc_ctrl
    import emxc_pkg::*;
#(
    parameter logic [15:0] ROM_TOP  = 16'h8000,
    parameter logic [15:0] RAM_BASE = 16'hfb00
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                srst,
    // AXI4-Lite register slave
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    output      logic [1:0]          s_axi_bresp,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    output      logic [31:0]         s_axi_rdata,
    output      logic [1:0]          s_axi_rresp,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // CPU memory access
    input  wire logic                cpu_req,
    input  wire logic [15:0]         cpu_addr,
    input  wire logic                cpu_write,
    input  wire logic [7:0]          cpu_wdata,
    output      logic                cpu_ack,
    output      logic                cpu_ext,
    output      logic                cpu_undef,
    output      logic [7:0]          cpu_rdata,
    // Port latch values from the port block
    input  wire logic [7:0]          gpio_p4_o,
    input  wire logic [7:0]          gpio_p4_oe,
    input  wire logic [7:0]          gpio_p5_o,
    input  wire logic [7:0]          gpio_p5_oe,
    input  wire logic [3:0]          gpio_p6_o,
    input  wire logic [3:0]          gpio_p6_oe,
    // Pins
    input  wire logic [7:0]          p4_i,
    input  wire logic                wait_n_i,
    output      logic [7:0]          p4_o,
    output      logic [7:0]          p4_oe,
    output      logic [7:0]          p5_o,
    output      logic [7:0]          p5_oe,
    output      logic [3:0]          p6_o,
    output      logic [3:0]          p6_oe,
    // Mode flags
    output      logic                p4_edge_mode,
    output      logic                wait_pin_is_bus
);

    // Largest window must end below internal RAM
    if (32'(ROM_TOP) + 32'(WIN_16K) > 32'(RAM_BASE)) begin : g_map_check
        $error("emxc_ctrl: external window overlaps internal RAM");
    end

    typedef struct packed {
        // Sequencer and registers
        emxc_state_t        st;
        logic [2:0]         area;
        logic [1:0]         waitc;
        logic               edge_mode;
        logic               wait_bus;

        // Write channel
        logic               aw_got;
        logic               w_got;
        logic [AXI_AW-1:0]  awaddr;
        logic [7:0]         wbyte;
        logic               wlane;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;

        // Read channel
        logic               arready;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [31:0]        rdata;

        // CPU cycle
        logic [15:0]        cur_addr;
        logic               cur_we;
        logic               cur_ext;
        logic               cur_undef;
        logic [7:0]         cur_wdata;
        logic               ack;
        logic [7:0]         rbyte;

        // Pin drive
        logic [7:0]         p4_o;
        logic [7:0]         p4_oe;
        logic [7:0]         p5_o;
        logic [7:0]         p5_oe;
        logic [3:0]         p6_o;
        logic [3:0]         p6_oe;
    } emxc_regs_t;

    emxc_regs_t s_reg;
    emxc_regs_t s_next;

    // Codes 010 and 110 fall back to single-chip
    function automatic logic is_expansion(input logic [2:0] area);
        return area == AREA_256B || area == AREA_4K || area == AREA_16K ||
               area == AREA_FULL;
    endfunction

    function automatic logic is_internal(input logic [15:0] addr);
        return addr < ROM_TOP || addr >= RAM_BASE;
    endfunction

    // Window opens right above internal ROM; full mode takes everything else
    function automatic logic in_window(input logic [15:0] addr, input logic [2:0] area);
        logic [16:0] lim;
        lim = 17'(ROM_TOP);
        unique case (area)
            AREA_256B: lim = 17'(ROM_TOP) + WIN_256B;
            AREA_4K:   lim = 17'(ROM_TOP) + WIN_4K;
            AREA_16K:  lim = 17'(ROM_TOP) + WIN_16K;
            AREA_FULL: lim = 17'h10000;
            default:   lim = 17'(ROM_TOP);
        endcase
        return !is_internal(addr) && 17'(addr) < lim;
    endfunction

    // Port 5 bits claimed as upper address
    function automatic logic [7:0] hi_mask(input logic [2:0] area);
        unique case (area)
            AREA_4K:   return HI_MASK_4K;
            AREA_16K:  return HI_MASK_16K;
            AREA_FULL: return HI_MASK_FULL;
            default:   return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [AXI_AW-1:0] a,
                                            input logic [2:0] area,
                                            input logic [1:0] waitc);
        if (a[AXI_AW-1:2] == AREA_SEL_IDX) begin
            return {5'h00, area};
        end
        return 8'((waitc << WAIT_LSB) & WAIT_CFG_MASK);
    endfunction

    function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
        return a[AXI_AW-1:2] == AREA_SEL_IDX || a[AXI_AW-1:2] == WAIT_CFG_IDX;
    endfunction

    logic bus_mode;
    logic ext_wait;
    logic strobing;
    logic [7:0] hmask;
    logic hit_win;

    always_comb begin
        s_next = s_reg;
        bus_mode = is_expansion(s_reg.area);
        ext_wait = s_reg.waitc == WAIT_EXT;
        hit_win = 1'b0;

        // Register write: address and data may come in either order
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.w_got = 1'b1;
            s_next.wbyte = s_axi_wdata[7:0];
            s_next.wlane = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Both halves in and no answer pending
        if (s_next.aw_got && s_next.w_got && !s_next.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = reg_hit(s_next.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_next.wlane && s_next.awaddr[AXI_AW-1:2] == AREA_SEL_IDX) begin
                s_next.area = s_next.wbyte[2:0];
            end
            if (s_next.wlane && s_next.awaddr[AXI_AW-1:2] == WAIT_CFG_IDX) begin
                s_next.waitc = s_next.wbyte[WAIT_LSB +: 2];
            end
        end

        // Readies stay low while an answer waits
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;

        // Register read
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && s_axi_arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = {24'h000000,
                            reg_read(s_axi_araddr, s_reg.area, s_reg.waitc)};
            s_next.rresp = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            // Unmapped reads give zero data
            if (!reg_hit(s_axi_araddr)) begin
                s_next.rdata = 32'h00000000;
            end
        end
        s_next.arready = !s_next.rvalid;

        // Mode flags leave on a flop like the other outputs
        s_next.edge_mode = s_next.area == AREA_EDGE;
        s_next.wait_bus = is_expansion(s_next.area) && s_next.waitc == WAIT_EXT;

        // CPU bus cycle sequencer
        s_next.ack = 1'b0;
        unique case (s_reg.st)
            ST_IDLE: begin
                // Request still up in the ack cycle is the old one
                if (cpu_req && !s_reg.ack) begin
                    s_next.st = ST_ADDR;
                    s_next.cur_addr = cpu_addr;
                    s_next.cur_we = cpu_write;
                    s_next.cur_wdata = cpu_wdata;
                    hit_win = bus_mode && in_window(cpu_addr, s_reg.area);
                    s_next.cur_ext = hit_win;
                    s_next.cur_undef = !is_internal(cpu_addr) && !hit_win;
                end
            end
            ST_ADDR: begin
                // Internal cycles still get the address strobe, never rd or wr
                s_next.st = s_reg.cur_ext ? ST_STROBE : ST_DONE;
                s_next.rbyte = s_reg.cur_undef ? UNDEF_DATA : 8'h00;
            end
            ST_STROBE: begin
                // Code 10 is treated as no wait
                if (s_reg.waitc == WAIT_ONE) begin
                    s_next.st = ST_WAIT1;
                end else if (!(ext_wait && !wait_n_i)) begin
                    s_next.st = ST_DONE;
                    s_next.rbyte = p4_i;
                end
            end
            ST_WAIT1: begin
                // Data lines sampled after the inserted wait
                s_next.st = ST_DONE;
                s_next.rbyte = p4_i;
            end
            ST_DONE: begin
                // Answer stands for exactly one cycle
                s_next.st = ST_IDLE;
                s_next.ack = 1'b1;
            end
        endcase

        // Pin multiplexer, computed for the cycle about to start
        strobing = s_next.st == ST_STROBE || s_next.st == ST_WAIT1;
        hmask = hi_mask(s_reg.area);
        s_next.p4_o = gpio_p4_o;
        s_next.p4_oe = gpio_p4_oe;
        s_next.p6_o = gpio_p6_o;
        s_next.p6_oe = gpio_p6_oe;
        for (int i = 0; i < 8; i++) begin
            s_next.p5_o[i] = hmask[i] ? s_next.cur_addr[8 + i] : gpio_p5_o[i];
            s_next.p5_oe[i] = hmask[i] ? 1'b1 : gpio_p5_oe[i];
        end

        if (bus_mode) begin
            // Bus owns port 4 even when idle, so no stray port drive collides
            s_next.p4_o = s_next.cur_addr[7:0];
            s_next.p4_oe = 8'h00;
            if (s_next.st == ST_ADDR) begin
                s_next.p4_oe = 8'hff;
            end else if (strobing && s_next.cur_we) begin
                s_next.p4_o = s_next.cur_wdata;
                s_next.p4_oe = 8'hff;
            end

            // Read and write strobes are low-active
            s_next.p6_o[P6_RD] = !(strobing && !s_next.cur_we);
            s_next.p6_o[P6_WR] = !(strobing && s_next.cur_we);
            s_next.p6_o[P6_ADDR_LATCH_STROBE] = s_next.st == ST_ADDR;
            s_next.p6_oe[P6_RD] = 1'b1;
            s_next.p6_oe[P6_WR] = 1'b1;
            s_next.p6_oe[P6_ADDR_LATCH_STROBE] = 1'b1;
            // Wait pin direction stays with the port latch in every case
            s_next.p6_o[P6_WAIT] = gpio_p6_o[P6_WAIT];
            s_next.p6_oe[P6_WAIT] = gpio_p6_oe[P6_WAIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.area <= AREA_SEL_RST[2:0];
            s_reg.waitc <= WAIT_CFG_RST[WAIT_LSB +: 2];
            s_reg.p6_o <= 4'h0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Register bus answers
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rdata = s_reg.rdata;

    // CPU answers
    assign cpu_ack = s_reg.ack;
    assign cpu_ext = s_reg.cur_ext;
    assign cpu_undef = s_reg.cur_undef;
    assign cpu_rdata = s_reg.rbyte;

    // Pins
    assign p4_o = s_reg.p4_o;
    assign p4_oe = s_reg.p4_oe;
    assign p5_o = s_reg.p5_o;
    assign p5_oe = s_reg.p5_oe;
    assign p6_o = s_reg.p6_o;
    assign p6_oe = s_reg.p6_oe;

    // Mode flags
    assign p4_edge_mode = s_reg.edge_mode;
    assign wait_pin_is_bus = s_reg.wait_bus;

endmodule

// [tb/emxc_ctrl_sva.sv]
// Checker for the expansion controller: strobe quietness, access timing, bus holds.
// Assumes it is bound to emxc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module emxc_ctrl_sva
    import emxc_pkg::*;
#(
    parameter logic [15:0] ROM_TOP  = 16'h8000,
    parameter logic [15:0] RAM_BASE = 16'hfb00
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // Register bus answers
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // CPU access
    input wire logic        cpu_req,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_write,
    input wire logic        cpu_ack,
    input wire logic        cpu_ext,
    input wire logic        cpu_undef,
    input wire logic [7:0]  cpu_rdata,
    // Port 6 strobes
    input wire logic [3:0]  gpio_p6_oe,
    input wire logic [3:0]  p6_o,
    input wire logic [3:0]  p6_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    wire in_int = (cpu_addr < ROM_TOP) || (cpu_addr >= RAM_BASE);

    a_int_access: assert property ($rose(cpu_req) && in_int |-> ##3 cpu_ack && !cpu_ext && !cpu_undef)
        else $error("internal access not answered after three cycles");
    a_addr_latch_strobe_every: assert property ($rose(cpu_req) && p6_oe[P6_ADDR_LATCH_STROBE] |=> p6_o[P6_ADDR_LATCH_STROBE])
        else $error("address strobe missing after request");
    a_rd_quiet: assert property (cpu_ack && !cpu_ext && p6_oe[P6_RD] |-> $past(p6_o[P6_RD]) && $past(p6_o[P6_RD], 2))
        else $error("read strobe pulsed on a non-external access");
    a_wr_quiet: assert property (cpu_ack && p6_oe[P6_WR] && !(cpu_ext && cpu_write) |-> $past(p6_o[P6_WR]) && $past(p6_o[P6_WR], 2))
        else $error("write strobe pulsed outside an external write");
    a_rd_to_ack: assert property ($fell(p6_o[P6_RD]) && p6_oe[P6_RD] && cpu_req |-> ##[2:40] cpu_ack)
        else $error("read strobe not followed by completion");
    a_undef_data: assert property (cpu_ack && cpu_undef && !cpu_write |-> cpu_rdata == UNDEF_DATA)
        else $error("undefined read did not return the filler byte");
    a_wait_dir: assert property (!$past(srst) |-> p6_oe[P6_WAIT] == $past(gpio_p6_oe[P6_WAIT]))
        else $error("wait pin direction left the port latch");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before acceptance");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before acceptance");

    c_ext_write: cover property (cpu_ack && cpu_ext && cpu_write);
    c_ext_read: cover property (cpu_ack && cpu_ext && !cpu_write);
    c_undef: cover property (cpu_ack && cpu_undef);
endmodule

bind emxc_ctrl emxc_ctrl_sva #(.ROM_TOP(ROM_TOP), .RAM_BASE(RAM_BASE)) i_sva (
    .mclk, .srst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .cpu_req, .cpu_addr, .cpu_write, .cpu_ack, .cpu_ext, .cpu_undef,
    .cpu_rdata, .gpio_p6_oe, .p6_o, .p6_oe);

// [tb/emxc_mem_model.sv]
// Behavioural external memory on the multiplexed bus, with a wait generator.
// Assumes the controller's port 6 strobe order and an address latch on the strobe.
`timescale 1ns/1ps
module emxc_mem_model
    import emxc_pkg::*;
(
    // Clock
    input  wire logic       mclk,
    // Bus pins from the controller
    input  wire logic [7:0] p4_o,
    input  wire logic [7:0] p5_o,
    input  wire logic [7:0] p5_oe,
    input  wire logic [3:0] p6_o,
    input  wire logic [3:0] p6_oe,
    // Test controls
    input  wire logic [7:0] waits,
    input  wire logic       hold,
    // Answers
    output      logic [7:0] p4_i,
    output      logic       wait_n_i
);
    logic [7:0]  mem [0:65535];
    logic [15:0] adr_q  = 16'h0000;
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  act    = 8'h00;
    wire         rd_low = p6_oe[P6_RD] && !p6_o[P6_RD];
    wire         wr_low = p6_oe[P6_WR] && !p6_o[P6_WR];

    // Undriven upper lines read low, so unclaimed undriven port bits latch as zero in adr_q
    always @(posedge mclk) begin
        if (p6_oe[P6_ADDR_LATCH_STROBE] && p6_o[P6_ADDR_LATCH_STROBE]) adr_q <= {p5_o & p5_oe, p4_o};
        if (wr_low) mem[adr_q] <= p4_o;
        if (rd_low) last_q <= p4_i;
        act <= (rd_low || wr_low) ? act + 8'h01 : 8'h00;
    end
    // Released bus shows the inverse of the last byte, never a stale copy
    assign p4_i     = rd_low ? mem[adr_q] : ~last_q;
    // Pulled-up wait line, held low for the first waits cycles of a strobe
    assign wait_n_i = !(hold || ((rd_low || wr_low) && act < waits));
endmodule

// [tb/tb.sv]
// Self-checking bench for the expansion controller with an external memory model.
// Assumes the hand-over timing: CPU answer 3 cycles internal, 4 external plus waits.
`timescale 1ns/1ps
module tb;
    import emxc_pkg::*;
    localparam logic [15:0] ROM_TOP  = 16'h8000;
    localparam logic [15:0] RAM_BASE = 16'hfb00;
    localparam logic [17:0] A_AREA   = {AREA_SEL_IDX, 2'b00};
    localparam logic [17:0] A_WAIT   = {WAIT_CFG_IDX, 2'b00};

    logic              mclk = 1'b0, srst = 1'b1, hold = 1'b0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = '0, gpio_p6_o = 4'hf, gpio_p6_oe = 4'hf, p6_o, p6_oe;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              cpu_req = 1'b0, cpu_write = 1'b0, cpu_ack, cpu_ext, cpu_undef;
    logic [15:0]       cpu_addr = '0;
    logic [7:0]        cpu_wdata = '0, cpu_rdata, waits = 8'h00;
    logic [7:0]        gpio_p4_o = 8'h3c, gpio_p4_oe = 8'hff, gpio_p5_o = 8'hc3, gpio_p5_oe = 8'h00;
    logic [7:0]        p4_i, p4_o, p4_oe, p5_o, p5_oe;
    logic              wait_n_i, p4_edge_mode, wait_pin_is_bus;
    int                n_mismatch = 0, checked = 0, cycles = 0;

    emxc_ctrl #(.ROM_TOP(ROM_TOP), .RAM_BASE(RAM_BASE)) i_dut (
        .mclk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_addr,
        .cpu_write, .cpu_wdata, .cpu_ack, .cpu_ext, .cpu_undef, .cpu_rdata, .gpio_p4_o,
        .gpio_p4_oe, .gpio_p5_o, .gpio_p5_oe, .gpio_p6_o, .gpio_p6_oe, .p4_i, .wait_n_i,
        .p4_o, .p4_oe, .p5_o, .p5_oe, .p6_o, .p6_oe, .p4_edge_mode, .wait_pin_is_bus);
    emxc_mem_model i_mem (.mclk, .p4_o, .p5_o, .p5_oe, .p6_o, .p6_oe, .waits, .hold, .p4_i,
        .wait_n_i);

    initial begin
        forever #50 mclk = ~mclk;
    end
    // Whole run needs a few hundred cycles; far beyond that means a hang
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Each channel held until its ready; bready stays up until bvalid
    task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic axi_rd(input logic [17:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
        chk(s_axi_rdata, {24'h0, ed});
    endtask

    // en counts edges from presenting the request to the edge that sees cpu_ack
    task automatic cpu(input logic [15:0] a, input logic w, input logic [7:0] d, input int en,
                       input logic [7:0] ed, input logic [1:0] eu);
        int n;
        n = 0;
        @(posedge mclk);
        cpu_addr  <= a;
        cpu_write <= w;
        cpu_wdata <= d;
        cpu_req   <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (cpu_ack !== 1'b1 && n < 60);
        cpu_req <= 1'b0;
        chk(n, en);
        chk({cpu_ext, cpu_undef}, eu);
        if (!w) chk(cpu_rdata, ed);
    endtask

    task automatic t_regs();
        axi_rd(A_AREA, AREA_SEL_RST, RESP_OKAY);
        axi_rd(A_WAIT, WAIT_CFG_RST, RESP_OKAY);
        axi_wr(A_AREA, 8'hff, RESP_OKAY);
        axi_rd(A_AREA, 8'h07, RESP_OKAY);
        axi_wr(A_WAIT, 8'hcf, RESP_OKAY);
        axi_rd(A_WAIT, 8'h00, RESP_OKAY);
        axi_wr(18'h00100, 8'h01, RESP_SLVERR);
        axi_rd(18'h00100, 8'h00, RESP_SLVERR);
    endtask

    task automatic t_single();
        axi_wr(A_AREA, {5'h0, AREA_SINGLE}, RESP_OKAY);
        cpu(16'h0040, 1'b0, 8'h00, 4, 8'h00, 2'b00);
        cpu(ROM_TOP, 1'b0, 8'h00, 4, UNDEF_DATA, 2'b01);
        chk({p4_o, p4_oe, p5_o, p5_oe}, {gpio_p4_o, gpio_p4_oe, gpio_p5_o, gpio_p5_oe});
        chk({p6_o, p6_oe}, {gpio_p6_o, gpio_p6_oe});
    endtask

    // Every area code; the far end of each window is written, read back and, except in full mode, overrun
    task automatic t_modes();
        logic [15:0] top;
        logic [15:0] a;
        logic [7:0]  hm;
        logic [7:0]  d;
        for (int c = 0; c < 8; c++) begin
            axi_wr(A_AREA, 8'(c), RESP_OKAY);
            chk(p4_edge_mode, c == 1);
            top = (c == 3) ? 16'h0100 : (c == 4) ? 16'h1000 : (c == 5) ? 16'h4000 :
                  (c == 7) ? RAM_BASE - ROM_TOP : 16'h0000;
            if (top == 16'h0000) begin
                cpu(ROM_TOP, 1'b0, 8'h00, 4, UNDEF_DATA, 2'b01);
            end else begin
                a = ROM_TOP + top - 16'h0001;
                hm = (c == 7) ? 8'hff : 8'((top - 16'h0001) >> 8);
                d = 8'(c) ^ 8'ha5;
                cpu(a, 1'b1, d, 5, 8'h00, 2'b10);
                cpu(a, 1'b0, 8'h00, 5, d, 2'b10);
                chk(i_mem.adr_q, {a[15:8] & hm, a[7:0]});
                chk({p4_oe, p5_oe, p6_o, p6_oe}, {8'h00, hm, 4'h7, 4'hf});
                if (c != 7) cpu(ROM_TOP + top, 1'b0, 8'h00, 4, UNDEF_DATA, 2'b01);
            end
        end
    endtask

    // Full-address mode stays selected; each wait code on a write then a read
    task automatic t_waits();
        int en;
        waits <= 8'h03;
        gpio_p6_oe <= 4'hb;
        for (int w = 0; w < 4; w++) begin
            axi_wr(A_WAIT, 8'(w << WAIT_LSB), RESP_OKAY);
            chk(wait_pin_is_bus, w == 3);
            en = (w == 1) ? 6 : (w == 3) ? 5 + waits : 5;
            cpu(ROM_TOP + 16'(w), 1'b1, 8'(w) ^ 8'h3c, en, 8'h00, 2'b10);
            cpu(ROM_TOP + 16'(w), 1'b0, 8'h00, en, 8'(w) ^ 8'h3c, 2'b10);
        end
        hold <= 1'b1;
        cpu(16'h0040, 1'b0, 8'h00, 4, 8'h00, 2'b00);
        hold <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_single();
        t_modes();
        t_waits();
        conclude();
    end
endmodule
